// >>> dv/analog_pins.sv
// Model of the analog voltage pair feeding the comparator
`default_nettype none
module analog_pins (
  input wire logic [11:0] positive_mv,
  input wire logic [11:0] negative_mv,
  output logic positive_above_negative
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ideal comparator, no hysteresis, so edges follow the voltages exactly
  assign positive_above_negative = positive_mv > negative_mv;
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the comparator digital block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, io_wr, io_rd, global_irq_enable, vector_taken, pa, clk_en;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata;
  logic [3:0] pin_raw, pin_buffer_off, pin_value;
  logic irq_req, capture_out, comparator_power_off;
  logic [11:0] vp, vn;
  int error_cnt, compares, cycles;
  analog_pins i_analog_pins (.positive_mv(vp), .negative_mv(vn), .positive_above_negative(pa));
  comparator_top i_comparator_top (.mclk(mclk), .nrst(nrst), .clk_en(clk_en),
    .positive_above_negative(pa), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .global_irq_enable(global_irq_enable),
    .vector_taken(vector_taken), .pin_raw(pin_raw), .io_rdata(io_rdata),
    .irq_req(irq_req), .capture_out(capture_out),
    .comparator_power_off(comparator_power_off), .pin_buffer_off(pin_buffer_off),
    .pin_value(pin_value));
  // ********************
  // Helpers
  // ********************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
  endtask
  // Read data stands one cycle only, so it is looked at right after the taking edge
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    chk("io_rdata", io_rdata, e);
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_regs();
    rd(6'h1f, 8'h00);
    rd(6'h17, 8'h00);
    rd(6'h20, 8'h00);
    wr(6'h1f, 8'h60);
    rd(6'h1f, 8'h00);
    wr(6'h17, 8'hff);
    rd(6'h17, 8'h0f);
    chk("pin_buffer_off", {4'h0, pin_buffer_off}, 8'h0f);
    pin_raw = 4'hf;
    cyc(3);
    chk("pin_value", {4'h0, pin_value}, 8'h00);
    wr(6'h17, 8'h00);
    cyc(3);
    chk("pin_value", {4'h0, pin_value}, 8'h0f);
  endtask
  task automatic t_events();
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[7:0];
      wr(6'h1f, 8'h10 | m);
      vp = 12'h800;
      cyc(5);
      rd(6'h1f, 8'h20 | m | ((i == 0 || i == 3) ? 8'h10 : 8'h00));
      wr(6'h1f, 8'h10 | m);
      vp = 12'h000;
      cyc(5);
      rd(6'h1f, m | ((i == 0 || i == 2) ? 8'h10 : 8'h00));
    end
  endtask
  task automatic t_irq();
    wr(6'h1f, 8'h0b);
    global_irq_enable = 1'b1;
    vp = 12'h800;
    cyc(5);
    chk("irq_req", {7'h0, irq_req}, 8'h01);
    wr(6'h1f, 8'h0b);
    rd(6'h1f, 8'h3b);
    global_irq_enable = 1'b0;
    cyc(1);
    chk("irq_req", {7'h0, irq_req}, 8'h00);
    global_irq_enable = 1'b1;
    vector_taken = 1'b1;
    cyc(1);
    vector_taken = 1'b0;
    cyc(1);
    chk("irq_req", {7'h0, irq_req}, 8'h00);
    rd(6'h1f, 8'h2b);
    wr(6'h1f, 8'h03);
    vp = 12'h000;
    cyc(5);
  endtask
  task automatic t_route_power();
    wr(6'h1f, 8'h07);
    vp = 12'h800;
    cyc(5);
    chk("capture_out", {7'h0, capture_out}, 8'h01);
    wr(6'h1f, 8'h03);
    cyc(1);
    chk("capture_out", {7'h0, capture_out}, 8'h00);
    wr(6'h1f, 8'h83);
    cyc(3);
    chk("power_off", {7'h0, comparator_power_off}, 8'h01);
    rd(6'h1f, 8'h93);
  endtask
  // A write while the enable is low must leave every bit as it was
  task automatic t_freeze();
    clk_en = 1'b0;
    wr(6'h1f, 8'h00);
    clk_en = 1'b1;
    rd(6'h1f, 8'h93);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {nrst, io_wr, io_rd, global_irq_enable, vector_taken} = 5'h0;
    clk_en = 1'b1;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    pin_raw = 4'h0;
    vp = 12'h000;
    vn = 12'h400;
    repeat (6) @(posedge mclk);
    #1;
    nrst = 1'b1;
    t_regs();
    t_events();
    t_irq();
    t_route_power();
    t_freeze();
    finish_test();
  end
endmodule
`default_nettype wire

// >>> rtl/comparator_cfg.svh
// Constants for the comparator digital block
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH
`define OFS_INPUT_DISABLE 6'h17
`define OFS_CONTROL_STATUS 6'h1f
`define RST_INPUT_DISABLE 8'h00
`define RST_CONTROL_STATUS 8'h00
`define BIT_POWER_OFF 7
`define BIT_RESULT 5
`define BIT_EVENT_FLAG 4
`define BIT_IRQ_ENABLE 3
`define BIT_CAPTURE_ROUTE 2
`define MASK_INPUT_DISABLE 8'h0f
`endif

// >>> rtl/comparator_pkg.sv
// Types for the comparator digital block
`default_nettype none
package comparator_pkg;
  typedef enum logic [1:0] {
    mode_toggle = 2'b00,
    mode_reserved = 2'b01,
    mode_falling = 2'b10,
    mode_rising = 2'b11
  } event_mode_type;
endpackage
`default_nettype wire

// >>> rtl/comparator_sync_edge.sv
// Synchroniser and edge detector for the comparator result
`default_nettype none
module comparator_sync_edge (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic raw_in,
  edge_if.src edges
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } sync_state_type;
  sync_state_type st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.s1 = raw_in;
      st_d.s2 = st_q.s1;
      st_d.prev = st_q.s2;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign edges.level = st_q.s2;
  assign edges.rise = st_q.s2 & ~st_q.prev;
  assign edges.fall = ~st_q.s2 & st_q.prev;
endmodule
`default_nettype wire

// >>> rtl/comparator_top.sv
// Comparator digital block: registers, events and interrupt request
`include "comparator_cfg.svh"
`default_nettype none
module comparator_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic positive_above_negative,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic global_irq_enable,
  input wire logic vector_taken,
  input wire logic [3:0] pin_raw,
  output logic [7:0] io_rdata,
  output logic irq_req,
  output logic capture_out,
  output logic comparator_power_off,
  output logic [3:0] pin_buffer_off,
  output logic [3:0] pin_value
);
  import comparator_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic power_off;
    logic flag;
    logic irq_en;
    logic route;
    event_mode_type mode;
    logic [3:0] in_dis;
    logic [7:0] rdata;
    logic irq;
    logic capture;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_val;
  } top_state_type;

  top_state_type st_q, st_d;
  edge_if edges ();
  logic raw_result;
  logic event_hit;

  // Raw result arrives asynchronously from the analog core
  assign raw_result = positive_above_negative & ~st_q.power_off;

  comparator_sync_edge u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .raw_in(raw_result),
    .edges(edges)
  );

  function automatic logic mode_match(input event_mode_type m, input logic r, input logic f);
    case (m)
      mode_toggle: mode_match = r | f;
      mode_falling: mode_match = f;
      mode_rising: mode_match = r;
      default: mode_match = 1'b0; // Reserved code raises nothing
    endcase
  endfunction

  assign event_hit = mode_match(st_q.mode, edges.rise, edges.fall);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      if (io_wr && io_addr == `OFS_CONTROL_STATUS) begin
        st_d.power_off = io_wdata[`BIT_POWER_OFF];
        st_d.irq_en = io_wdata[`BIT_IRQ_ENABLE];
        st_d.route = io_wdata[`BIT_CAPTURE_ROUTE];
        st_d.mode = event_mode_type'(io_wdata[1:0]);
        if (io_wdata[`BIT_EVENT_FLAG]) begin
          st_d.flag = 1'b0;
        end
      end
      if (io_wr && io_addr == `OFS_INPUT_DISABLE) begin
        st_d.in_dis = io_wdata[3:0];
      end
      if (vector_taken) begin
        st_d.flag = 1'b0;
      end
      // Set wins over any clear in the same cycle
      if (event_hit) begin
        st_d.flag = 1'b1;
      end
      st_d.irq = st_d.flag & st_d.irq_en & global_irq_enable;
      st_d.capture = st_q.route & edges.level;
      st_d.pin_s1 = pin_raw;
      st_d.pin_s2 = st_q.pin_s1;
      st_d.pin_val = st_q.pin_s2 & ~st_q.in_dis;
      st_d.rdata = 8'h00;
      if (io_rd && io_addr == `OFS_CONTROL_STATUS) begin
        st_d.rdata = {st_q.power_off, 1'b0, edges.level, st_q.flag,
                      st_q.irq_en, st_q.route, st_q.mode};
      end else if (io_rd && io_addr == `OFS_INPUT_DISABLE) begin
        st_d.rdata = {4'h0, st_q.in_dis};
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign io_rdata = st_q.rdata;
  assign irq_req = st_q.irq;
  assign capture_out = st_q.capture;
  assign comparator_power_off = st_q.power_off;
  assign pin_buffer_off = st_q.in_dis;
  assign pin_value = st_q.pin_val;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_flag_set_event: assert property (clk_en && event_hit |=> st_q.flag)
    else $error("event did not set flag");
  a_flag_write_clear: assert property (clk_en && io_wr && io_addr == `OFS_CONTROL_STATUS
    && io_wdata[`BIT_EVENT_FLAG] && !event_hit |=> !st_q.flag)
    else $error("write one did not clear flag");
  a_flag_vector_clear: assert property (clk_en && vector_taken && !event_hit |=> !st_q.flag)
    else $error("vector did not clear flag");
  a_irq_needs_all: assert property (irq_req |-> $past(st_d.flag) && st_q.irq_en)
    else $error("irq without cause");
  a_mode_reserved: assert property (clk_en && st_q.mode == mode_reserved && !st_q.flag
    && !(io_wr || vector_taken) |=> !st_q.flag)
    else $error("reserved mode set flag");
  a_rising_only: assert property (clk_en && st_q.mode == mode_rising && edges.fall
    && !st_q.flag && !io_wr |=> !st_q.flag)
    else $error("falling edge flagged in rising mode");
  a_result_sync: assert property (clk_en [*3] ##0 $stable(raw_result) [*3]
    |-> edges.level == raw_result)
    else $error("result not synced in two cycles");
  a_pin_gated: assert property (clk_en && st_q.in_dis[0] |=> !pin_value[0])
    else $error("disabled pin reads one");
  a_capture_route: assert property (!st_q.route && clk_en |=> !capture_out)
    else $error("capture driven while unrouted");
  a_power_off: assert property ((clk_en && st_q.power_off) [*4] |-> !edges.level)
    else $error("result high while off");

  c_rise_event: cover property (st_q.mode == mode_rising && edges.rise);
  c_irq_raised: cover property (irq_req);
  c_clear_race: cover property (event_hit && vector_taken);
endmodule
`default_nettype wire

// >>> rtl/edge_if.sv
// Interface from edge detector to the register block
`default_nettype none
interface edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire
